// >>> design/tdl_pkg.sv
// constants and shared helpers for the t1 data-link overhead block
package tdl_pkg;

   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W        = 11;
   localparam int unsigned OFS_W         = 9;
   localparam logic [8:0]  OFS_RX_CTL1   = 9'h003;
   localparam logic [8:0]  OFS_RX_CTL2   = 9'h014;
   localparam logic [8:0]  OFS_RX_CODE_C = 9'h015;
   localparam logic [8:0]  OFS_RX_LINK   = 9'h062;
   localparam logic [8:0]  OFS_RX_CODE_V = 9'h063;
   localparam logic [8:0]  OFS_RX_MSG1   = 9'h064;
   localparam logic [8:0]  OFS_RX_MSG2   = 9'h065;
   localparam logic [8:0]  OFS_RX_MSG3   = 9'h066;
   localparam logic [8:0]  OFS_RX_LS7    = 9'h096;
   localparam logic [8:0]  OFS_RX_IM7    = 9'h0a6;
   localparam logic [8:0]  OFS_TX_HDLC2  = 9'h113;
   localparam logic [8:0]  OFS_TX_LINK   = 9'h162;
   localparam logic [8:0]  OFS_TX_CODE   = 9'h163;
   localparam logic [8:0]  OFS_PORT_MODE = 9'h180;
   localparam logic [8:0]  OFS_TX_CTL1   = 9'h181;
   localparam logic [8:0]  OFS_TX_CTL2   = 9'h182;
   localparam logic [8:0]  OFS_TX_LS2    = 9'h191;
   localparam logic [8:0]  OFS_TX_IM2    = 9'h1a1;
   localparam int unsigned NUM_PORTS     = 4;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned RC1_CROSS_BIT = 3;
   localparam int unsigned RC1_D4_BIT    = 5;
   localparam int unsigned RC1_SYNC_TIME_SELECT_BIT = 7;
   localparam int unsigned RC2_LOOP_BIT  = 4;
   localparam int unsigned CC_FILT_LSB   = 0;
   localparam int unsigned CC_DIS_LSB    = 2;
   localparam int unsigned LS7_DET_BIT   = 0;
   localparam int unsigned LS7_CLR_BIT   = 1;
   localparam int unsigned LS7_FULL_BIT  = 2;
   localparam int unsigned LS7_LOOP_BIT  = 3;
   localparam int unsigned TX_HDLC_CONTROL_TWO_SEND_BIT = 6;
   localparam int unsigned TC1_PASS_BIT  = 6;
   localparam int unsigned TC2_SRC_BIT   = 7;
   localparam int unsigned TX_LATCHED_STATUS_TWO_EMP_BIT  = 4;
   localparam int unsigned MODE_E1_BIT   = 0;
   localparam int unsigned MODE_TXD4_BIT = 1;

   // ---------------------------------------------------------------
   // counts and patterns
   // ---------------------------------------------------------------
   localparam logic [3:0]  ESF_BYTE_BITS = 4'h8;
   localparam logic [3:0]  D4_BYTE_BITS  = 4'h6;
   localparam logic [3:0]  FILT_N [4]    = '{4'h1, 4'h3, 4'h5, 4'h7};
   localparam logic [7:0]  DIS_N [4]     = '{8'h10, 8'h20, 8'h40, 8'h80};
   localparam logic [7:0]  CODE_RUN_GAP  = 8'h10;
   localparam logic [11:0] LOOP_ALIGN    = 12'h1c7;
   localparam logic [5:0]  LOOP_FS_BITS  = 6'h24;
   localparam logic [7:0]  CODE_FLAG     = 8'hff;

   // ---------------------------------------------------------------
   // code word helpers, bit 15 goes on the line first
   // ---------------------------------------------------------------
   function automatic logic [15:0] code_seq(input logic [5:0] c);
      code_seq = {CODE_FLAG, 1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0};
   endfunction

   function automatic logic [5:0] code_of(input logic [15:0] w);
      code_of = {w[1], w[2], w[3], w[4], w[5], w[6]};
   endfunction

endpackage

// >>> design/tdl_code_det.sv
// receive bit-oriented code detector with filter and disintegration timing
`timescale 1ns/1ps
module tdl_code_det
   import tdl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       bit_stb,
   input  wire logic       bit_in,
   input  wire logic       enable,
   input  wire logic [1:0] filt_sel,
   input  wire logic [1:0] dis_sel,
   output logic            det_pulse,
   output logic            clr_pulse,
   output logic [5:0]      code
);
   typedef struct packed {
      logic [15:0] win;
      logic [5:0]  cand;
      logic [3:0]  cnt;
      logic [7:0]  miss;
      logic        rep_valid;
      logic [5:0]  rep_code;
      logic        det;
      logic        clr;
   } tdl_det_st_t;

   tdl_det_st_t st_q;
   tdl_det_st_t st_d;

   always_comb begin
      logic [15:0] w;
      logic [5:0]  c;
      w = {st_q.win[14:0], bit_in};
      c = code_of(w);
      st_d = st_q;
      st_d.det = 1'b0;
      st_d.clr = 1'b0;
      if (!enable) begin
         st_d.cnt = '0;
         st_d.miss = '0;
      end else if (bit_stb) begin
         st_d.win = w;
         if (w == code_seq(c)) begin
            st_d.miss = '0;
            if (st_q.cnt != '0 && c == st_q.cand) begin
               if (st_q.cnt != 4'hf) begin
                  st_d.cnt = st_q.cnt + 4'h1;
               end
            end else begin
               st_d.cand = c;
               st_d.cnt = 4'h1;
            end
            if (st_d.cnt >= FILT_N[filt_sel]
                && (!st_q.rep_valid || st_q.rep_code != c)) begin
               st_d.det = 1'b1;
               st_d.rep_valid = 1'b1;
               st_d.rep_code = c;
            end
         end else begin
            if (st_q.miss != 8'hff) begin
               st_d.miss = st_q.miss + 8'h01;
            end
            if (st_d.miss > CODE_RUN_GAP) begin
               st_d.cnt = '0;
            end
            if (st_d.miss == DIS_N[dis_sel] && st_q.rep_valid) begin
               st_d.clr = 1'b1;
               st_d.rep_valid = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign det_pulse = st_q.det;
   assign clr_pulse = st_q.clr;
   assign code      = st_q.rep_code;
endmodule

// >>> design/tdl_loop_extract.sv
// receive subscriber-loop multiframe message extractor
`timescale 1ns/1ps
module tdl_loop_extract
   import tdl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       fs_stb,
   input  wire logic       fs_bit,
   input  wire logic       enable,
   output logic            ready_pulse,
   output logic [7:0]      msg1,
   output logic [7:0]      msg2,
   output logic [7:0]      msg3
);
   typedef struct packed {
      logic [35:0] hist;
      logic        locked;
      logic [5:0]  cnt;
      logic [23:0] msg;
      logic        rdy;
   } tdl_loop_st_t;

   tdl_loop_st_t st_q;
   tdl_loop_st_t st_d;

   always_comb begin
      logic [35:0] h;
      logic        hit;
      h = {st_q.hist[34:0], fs_bit};
      hit = (h[35:24] == LOOP_ALIGN);
      st_d = st_q;
      st_d.rdy = 1'b0;
      if (!enable) begin
         st_d.locked = 1'b0;
         st_d.cnt = '0;
      end else if (fs_stb) begin
         st_d.hist = h;
         st_d.cnt = st_q.cnt + 6'h01;
         if (!st_q.locked || st_d.cnt == LOOP_FS_BITS) begin
            st_d.cnt = '0;
            st_d.locked = hit;
            if (hit) begin
               st_d.msg = h[23:0];
               st_d.rdy = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign ready_pulse = st_q.rdy;
   assign msg1        = st_q.msg[23:16];
   assign msg2        = st_q.msg[15:8];
   assign msg3        = st_q.msg[7:0];
endmodule

// >>> design/tdl_overhead.sv
// per-port t1 data-link overhead: registers, code and byte link paths
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module tdl_overhead
   import tdl_pkg::*;
#(
   parameter int unsigned PORT_INDEX = 1
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [tdl_pkg::ADDR_W-1:0] addr,
   input  wire logic [7:0]        wr_data,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic [7:0]             rd_data,
   input  wire logic              rx_frame_stb,
   input  wire logic              rx_dl_slot,
   input  wire logic              rx_fbit,
   input  wire logic              rx_sf_start,
   input  wire logic              tx_frame_stb,
   input  wire logic              tx_dl_slot,
   input  wire logic              tx_serial_data_input,
   output logic                   tx_fbit_out,
   output logic                   interrupt_out_n
);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (PORT_INDEX < 1 || PORT_INDEX > NUM_PORTS) begin : g_bad_port
      $error("tdl_overhead: PORT_INDEX out of range");
   end

   localparam logic [1:0] PORT_SEL = 2'(PORT_INDEX - 1);

   typedef struct packed {
      logic [7:0] rc1;
      logic [7:0] rc2;
      logic [7:0] cctl;
      logic [7:0] rx_interrupt_mask_seven;
      logic [7:0] tx_hdlc_control_two;
      logic [7:0] txb;
      logic [7:0] txc;
      logic [7:0] mode;
      logic [7:0] tc1;
      logic [7:0] tc2;
      logic [7:0] tx_interrupt_mask_two;
      logic [3:0] rx_latched_status_seven;
      logic       tx_latched_status_two;
      logic [7:0] rxb;
      logic [7:0] rxsh;
      logic [3:0] rxcnt;
      logic [7:0] txsh;
      logic [3:0] txcnt;
      logic [3:0] cidx;
      logic [5:0] ccode;
      logic       fout;
      logic [7:0] rdat;
      logic       irq_n;
   } tdl_top_st_t;

   tdl_top_st_t st_q;
   tdl_top_st_t st_d;

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   logic       hit;
   logic [8:0] ofs;
   logic       t1_mode;
   logic       rx_d4;
   logic       tx_d4;
   logic       rx_dl_stb;

   assign hit       = (addr[ADDR_W-1:OFS_W] == PORT_SEL);
   assign ofs       = addr[OFS_W-1:0];
   assign t1_mode   = !st_q.mode[MODE_E1_BIT];
   assign rx_d4     = st_q.rc1[RC1_D4_BIT];
   assign tx_d4     = st_q.mode[MODE_TXD4_BIT];
   assign rx_dl_stb = rx_frame_stb && rx_dl_slot && t1_mode;

   // ---------------------------------------------------------------
   // receive code detector and loop extractor
   // ---------------------------------------------------------------
   logic       det_pulse;
   logic       clr_pulse;
   logic [5:0] rx_code;
   logic       loop_rdy;
   logic [7:0] msg1;
   logic [7:0] msg2;
   logic [7:0] msg3;

   tdl_code_det u_det (
      .clk       (clk),
      .rst       (rst),
      .bit_stb   (rx_dl_stb),
      .bit_in    (rx_fbit),
      .enable    (t1_mode && !rx_d4),
      .filt_sel  (st_q.cctl[CC_FILT_LSB +: 2]),
      .dis_sel   (st_q.cctl[CC_DIS_LSB +: 2]),
      .det_pulse (det_pulse),
      .clr_pulse (clr_pulse),
      .code      (rx_code)
   );

   tdl_loop_extract u_loop (
      .clk         (clk),
      .rst         (rst),
      .fs_stb      (rx_dl_stb && rx_d4),
      .fs_bit      (rx_fbit),
      .enable      (st_q.rc2[RC2_LOOP_BIT] && rx_d4
                    && st_q.rc1[RC1_CROSS_BIT]),
      .ready_pulse (loop_rdy),
      .msg1        (msg1),
      .msg2        (msg2),
      .msg3        (msg3)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic       wr;
      logic [3:0] ls7_set;
      logic [3:0] ls7_clr;
      logic       emp_set;
      logic       emp_clr;
      logic       full_set;
      logic       sending;
      logic [15:0] seq;
      logic [3:0] blen;
      logic [7:0] src;
      logic       fb;
      wr       = wr_stb && hit;
      ls7_clr  = '0;
      emp_clr  = 1'b0;
      emp_set  = 1'b0;
      full_set = 1'b0;
      st_d     = st_q;

      // register writes; latched flags clear on writing one
      if (wr) begin
         unique case (ofs)
            OFS_RX_CTL1:   st_d.rc1 = wr_data;
            OFS_RX_CTL2:   st_d.rc2 = wr_data;
            OFS_RX_CODE_C: st_d.cctl = wr_data;
            OFS_RX_LS7:    ls7_clr = wr_data[3:0];
            OFS_RX_IM7:    st_d.rx_interrupt_mask_seven = wr_data;
            OFS_TX_HDLC2:  st_d.tx_hdlc_control_two = wr_data;
            OFS_TX_LINK:   st_d.txb = wr_data;
            OFS_TX_CODE:   st_d.txc = wr_data;
            OFS_PORT_MODE: st_d.mode = wr_data;
            OFS_TX_CTL1:   st_d.tc1 = wr_data;
            OFS_TX_CTL2:   st_d.tc2 = wr_data;
            OFS_TX_LS2:    emp_clr = wr_data[TX_LATCHED_STATUS_TWO_EMP_BIT];
            OFS_TX_IM2:    st_d.tx_interrupt_mask_two = wr_data;
            default:       st_d.rc1 = st_q.rc1;
         endcase
      end

      // receive byte link
      if (rx_dl_stb) begin
         st_d.rxsh = {rx_fbit, st_q.rxsh[7:1]};
         if (!rx_d4) begin
            st_d.rxcnt = st_q.rxcnt + 4'h1;
            if (st_d.rxcnt == ESF_BYTE_BITS) begin
               st_d.rxcnt = '0;
               st_d.rxb = st_d.rxsh;
               full_set = 1'b1;
            end
         end
      end
      if (rx_frame_stb && rx_sf_start && rx_d4 && t1_mode) begin
         st_d.rxb = {2'b00, st_q.rxsh[7:2]};
         st_d.rxcnt = '0;
         full_set = 1'b1;
      end

      // transmit data-link slot
      sending = st_q.tx_hdlc_control_two[TX_HDLC_CONTROL_TWO_SEND_BIT] && t1_mode && !tx_d4;
      seq  = code_seq(st_q.cidx == '0 ? st_q.txc[5:0] : st_q.ccode);
      blen = tx_d4 ? D4_BYTE_BITS : ESF_BYTE_BITS;
      src  = (st_q.txcnt == '0) ? st_q.txb : st_q.txsh;
      fb   = tx_serial_data_input;
      if (tx_frame_stb) begin
         if (tx_dl_slot && t1_mode && !st_q.tc1[TC1_PASS_BIT]) begin
            if (sending || st_q.cidx != '0) begin
               if (st_q.cidx == '0) begin
                  st_d.ccode = st_q.txc[5:0];
               end
               fb = seq[4'hf - st_q.cidx];
               st_d.cidx = st_q.cidx + 4'h1;
            end else if (!st_q.tc2[TC2_SRC_BIT]) begin
               fb = src[0];
               st_d.txsh = src >> 1;
               st_d.txcnt = st_q.txcnt + 4'h1;
               if (st_d.txcnt == blen) begin
                  st_d.txcnt = '0;
                  emp_set = 1'b1;
               end
            end
         end
         st_d.fout = fb;
      end

      // latched flags, a set in the same cycle beats the clear
      ls7_set = '0;
      ls7_set[LS7_DET_BIT]  = det_pulse;
      ls7_set[LS7_CLR_BIT]  = clr_pulse;
      ls7_set[LS7_FULL_BIT] = full_set;
      ls7_set[LS7_LOOP_BIT] = loop_rdy;
      st_d.rx_latched_status_seven = (st_q.rx_latched_status_seven & ~ls7_clr) | ls7_set;
      st_d.tx_latched_status_two = (st_q.tx_latched_status_two && !emp_clr) || emp_set;

      st_d.irq_n = !(|(st_d.rx_latched_status_seven & st_d.rx_interrupt_mask_seven[3:0])
                     || (st_d.tx_latched_status_two && st_d.tx_interrupt_mask_two[TX_LATCHED_STATUS_TWO_EMP_BIT]));

      // read data, valid the cycle after the strobe
      st_d.rdat = '0;
      if (rd_stb && hit) begin
         unique case (ofs)
            OFS_RX_CTL1:   st_d.rdat = st_q.rc1;
            OFS_RX_CTL2:   st_d.rdat = st_q.rc2;
            OFS_RX_CODE_C: st_d.rdat = st_q.cctl;
            OFS_RX_LINK:   st_d.rdat = st_q.rxb;
            OFS_RX_CODE_V: st_d.rdat = {2'b00, rx_code};
            OFS_RX_MSG1:   st_d.rdat = msg1;
            OFS_RX_MSG2:   st_d.rdat = msg2;
            OFS_RX_MSG3:   st_d.rdat = msg3;
            OFS_RX_LS7:    st_d.rdat = {4'h0, st_q.rx_latched_status_seven};
            OFS_RX_IM7:    st_d.rdat = st_q.rx_interrupt_mask_seven;
            OFS_TX_HDLC2:  st_d.rdat = st_q.tx_hdlc_control_two;
            OFS_TX_LINK:   st_d.rdat = st_q.txb;
            OFS_TX_CODE:   st_d.rdat = st_q.txc;
            OFS_PORT_MODE: st_d.rdat = st_q.mode;
            OFS_TX_CTL1:   st_d.rdat = st_q.tc1;
            OFS_TX_CTL2:   st_d.rdat = st_q.tc2;
            OFS_TX_LS2:    st_d.rdat = {3'b000, st_q.tx_latched_status_two, 4'h0};
            OFS_TX_IM2:    st_d.rdat = st_q.tx_interrupt_mask_two;
            default:       st_d.rdat = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.irq_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data         = st_q.rdat;
   assign tx_fbit_out     = st_q.fout;
   assign interrupt_out_n = st_q.irq_n;
endmodule

// >>> verification/tdl_overhead_monitor.sv
// assertion checker on the ports of one data-link overhead port
`timescale 1ns/1ps
module tdl_overhead_monitor #(
   parameter int unsigned PORT_INDEX = 1
)(
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic [tdl_pkg::ADDR_W-1:0] addr,
   input wire logic                       wr_stb,
   input wire logic                       rd_stb,
   input wire logic [7:0]                 rd_data,
   input wire logic                       rx_frame_stb,
   input wire logic                       tx_frame_stb,
   input wire logic                       tx_dl_slot,
   input wire logic                       tx_serial_data_input,
   input wire logic                       tx_fbit_out,
   input wire logic                       interrupt_out_n
);
   import tdl_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_rd_idle: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   a_rd_once: assert property (rd_stb ##1 !rd_stb |=> rd_data == 8'h00)
      else $error("read data held past one cycle");
   a_rd_other_port: assert property (rd_stb && addr[10:9] != 2'(PORT_INDEX - 1)
      |=> rd_data == 8'h00)
      else $error("foreign port address answered");
   a_rd_hole: assert property (rd_stb && addr[8:0] == 9'h1ff |=> rd_data == 8'h00)
      else $error("unmapped offset answered");
   a_tx_nonslot: assert property (tx_frame_stb && !tx_dl_slot
      |=> tx_fbit_out == $past(tx_serial_data_input))
      else $error("non-slot f bit not taken from serial input");
   a_tx_hold: assert property (!tx_frame_stb |=> $stable(tx_fbit_out))
      else $error("f bit changed without a frame strobe");
   a_int_fall: assert property ($fell(interrupt_out_n) |-> $past(rx_frame_stb)
      || $past(rx_frame_stb, 2) || $past(rx_frame_stb, 3) || $past(tx_frame_stb)
      || $past(tx_frame_stb, 2) || $past(wr_stb) || $past(wr_stb, 2) || $past(wr_stb, 3))
      else $error("interrupt asserted without a cause");
   a_int_release: assert property ($rose(interrupt_out_n)
      |-> $past(wr_stb) || $past(wr_stb, 2) || $past(wr_stb, 3))
      else $error("interrupt released without a host write");
   a_int_calm: assert property ((!rx_frame_stb && !tx_frame_stb && !wr_stb) [*4]
      |=> $stable(interrupt_out_n))
      else $error("interrupt moved while nothing happened");
endmodule

// >>> verification/tdl_far_end.sv
// far-end line model: sends a repeating f bit pattern and captures slot bits
`timescale 1ns/1ps
module tdl_far_end (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        run,
   input  wire logic [15:0] pat,
   input  wire logic        tx_fbit_out,
   output logic             rx_frame_stb,
   output logic             rx_dl_slot,
   output logic             rx_fbit,
   output logic             rx_sf_start,
   output logic             tx_frame_stb,
   output logic             tx_dl_slot,
   output logic             tx_serial_data_input,
   output logic [15:0]      cap,
   output logic [7:0]       ncap
);
   logic [1:0] ph_q;
   logic [4:0] fr_q;
   logic       run_q;
   logic       cap_q;
   // one frame every four clocks, data-link slot on odd frames
   assign rx_frame_stb = run_q && ph_q == 2'h0;
   assign tx_frame_stb = rx_frame_stb;
   assign rx_dl_slot = fr_q[0];
   assign tx_dl_slot = fr_q[0];
   assign rx_fbit = pat[4'hf - fr_q[4:1]];
   assign rx_sf_start = fr_q[3:0] == 4'h1;
   assign tx_serial_data_input = fr_q[1];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 2'h0;
         fr_q <= 5'h00;
         run_q <= 1'b0;
         cap_q <= 1'b0;
         cap <= 16'h0000;
         ncap <= 8'h00;
      end else begin
         run_q <= run;
         ph_q <= ph_q + 2'h1;
         cap_q <= tx_frame_stb && tx_dl_slot;
         if (rx_frame_stb) begin
            fr_q <= fr_q + 5'h01;
         end
         if (cap_q) begin
            cap <= {cap[14:0], tx_fbit_out};
            ncap <= ncap + 8'h01;
         end
      end
   end
endmodule

// >>> verification/tdl_overhead_tb.sv
// self-checking bench for one t1 data-link overhead port
`timescale 1ns/1ps
module tdl_overhead_tb;
   import tdl_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [10:0] addr = 11'h000;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic        run = 1'b0;
   logic [15:0] pat = 16'h0000;
   logic [7:0]  rd_data;
   logic        rfs, rds, rfb, rss, tfs, tds, tsd, tfo, int_n;
   logic [15:0] cap;
   logic [7:0]  ncap;
   int          num_errors = 0;
   int          check_count = 0;
   int          cyc = 0;
   always #12.5 clk = ~clk;
   tdl_overhead uut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .rx_frame_stb(rfs), .rx_dl_slot(rds), .rx_fbit(rfb),
      .rx_sf_start(rss), .tx_frame_stb(tfs), .tx_dl_slot(tds), .tx_serial_data_input(tsd),
      .tx_fbit_out(tfo), .interrupt_out_n(int_n));
   tdl_far_end far (.clk(clk), .rst(rst), .run(run), .pat(pat), .tx_fbit_out(tfo),
      .rx_frame_stb(rfs), .rx_dl_slot(rds), .rx_fbit(rfb), .rx_sf_start(rss),
      .tx_frame_stb(tfs), .tx_dl_slot(tds), .tx_serial_data_input(tsd), .cap(cap), .ncap(ncap));
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(16'(rd_data & m), 16'(e));
      @(posedge clk);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      run <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_int();
      repeat (3000) if (int_n !== 1'b0) begin @(posedge clk); #1; end
      chk(16'(int_n), 16'h0000);
   endtask
   task automatic wait_cap(input logic [7:0] k);
      repeat (1000) if (ncap !== k) begin @(posedge clk); #1; end
      chk(16'(ncap), 16'(k));
   endtask
   task automatic t_regs();
      rd(11'(OFS_TX_LINK), 8'hff, 8'h00);
      rd(11'(OFS_RX_LS7), 8'hff, 8'h00);
      chk(16'(int_n), 16'h0001);
      wr(11'(OFS_TX_LINK), 8'h5a);
      wr(11'h200 | 11'(OFS_TX_LINK), 8'h33);
      rd(11'(OFS_TX_LINK), 8'hff, 8'h5a);
      rd(11'h200 | 11'(OFS_TX_LINK), 8'hff, 8'h00);
      wr(11'(OFS_RX_CODE_V), 8'h15);
      rd(11'(OFS_RX_CODE_V), 8'hff, 8'h00);
      rd(11'h1ff, 8'hff, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_tx(input logic [7:0] md, input logic [7:0] b, input logic [15:0] m,
                       input logic [15:0] e);
      do_reset();
      wr(11'(OFS_PORT_MODE), md);
      wr(11'(OFS_TX_LINK), b);
      wr(11'(OFS_TX_IM2), 8'h10);
      run <= 1'b1;
      wait_int();
      rd(11'(OFS_TX_LS2), 8'h10, 8'h10);
      wr(11'(OFS_TX_LS2), 8'h10);
      #1 chk(16'(int_n), 16'h0001);
      wait_int();
      repeat (2) @(posedge clk);
      #1 chk(cap & m, e);
      $display("test tx byte done");
   endtask
   task automatic t_code();
      do_reset();
      wr(11'(OFS_TX_CODE), 8'hcb);
      wr(11'(OFS_TX_HDLC2), 8'h40);
      run <= 1'b1;
      wait_cap(8'h10);
      chk(cap, 16'hff68);
      wait_cap(8'h14);
      wr(11'(OFS_TX_HDLC2), 8'h00);
      wait_cap(8'h20);
      chk(cap, 16'hff68);
      wait_cap(8'h30);
      chk(cap, 16'h0000);
      wr(11'(OFS_TX_CTL1), 8'h40);
      wait_cap(8'h50);
      chk(cap, 16'h5555);
      $display("test tx code done");
   endtask
   task automatic t_rx();
      do_reset();
      pat <= 16'h68ff;
      wr(11'(OFS_RX_IM7), 8'h04);
      run <= 1'b1;
      wait_int();
      rd(11'(OFS_RX_LINK), 8'hff, 8'h16);
      wr(11'(OFS_RX_LS7), 8'h04);
      wr(11'(OFS_RX_IM7), 8'h01);
      wait_int();
      rd(11'(OFS_RX_CODE_V), 8'h3f, 8'h0b);
      wr(11'(OFS_RX_LS7), 8'h01);
      #1 chk(16'(int_n), 16'h0001);
      repeat (400) @(posedge clk);
      rd(11'(OFS_RX_LS7), 8'h01, 8'h00);
      pat <= 16'h0000;
      wr(11'(OFS_RX_IM7), 8'h02);
      wait_int();
      rd(11'(OFS_RX_LS7), 8'h02, 8'h02);
      $display("test rx done");
   endtask
   task automatic t_loop();
      do_reset();
      pat <= 16'h0000;
      wr(11'(OFS_RX_CTL1), 8'h28);
      wr(11'(OFS_RX_CTL2), 8'h10);
      wr(11'(OFS_RX_IM7), 8'h08);
      run <= 1'b1;
      repeat (600) @(posedge clk);
      rd(11'(OFS_RX_LS7), 8'h08, 8'h00);
      pat <= 16'h01c7;
      wait_int();
      rd(11'(OFS_RX_MSG1), 8'hff, 8'h01);
      rd(11'(OFS_RX_MSG2), 8'hff, 8'hc7);
      rd(11'(OFS_RX_MSG3), 8'hff, 8'h01);
      $display("test loop done");
   endtask
   task automatic t_e1();
      do_reset();
      pat <= 16'h68ff;
      wr(11'(OFS_PORT_MODE), 8'h01);
      run <= 1'b1;
      repeat (600) @(posedge clk);
      rd(11'(OFS_RX_LS7), 8'h07, 8'h00);
      rd(11'(OFS_RX_CODE_V), 8'hff, 8'h00);
      $display("test e1 done");
   endtask
   initial begin
      do_reset();
      t_regs();
      t_tx(8'h00, 8'h35, 16'hffff, 16'hacac);
      t_tx(8'h02, 8'h1c, 16'h0fff, 16'h038e);
      t_code();
      t_rx();
      t_loop();
      t_e1();
      end_sim();
   end
endmodule
bind tdl_overhead tdl_overhead_monitor #(.PORT_INDEX(PORT_INDEX)) mon (.clk(clk), .rst(rst),
   .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
   .rx_frame_stb(rx_frame_stb), .tx_frame_stb(tx_frame_stb), .tx_dl_slot(tx_dl_slot),
   .tx_serial_data_input(tx_serial_data_input), .tx_fbit_out(tx_fbit_out),
   .interrupt_out_n(interrupt_out_n));
